/* dv/hrw_host.sv */
// Purpose: host processor model on the parallel port
// Assumes: strobes low LOW plus slow cycles, high HIGH plus slow cycles
// Notes:   released data lines show the inverse of last value
`timescale 1ns/1ns
`include "hrw_consts.svh"

module hrw_host #(
   parameter int LOW  = 5,
   parameter int HIGH = 4
) (
   input  wire logic        clk_i,
   input  wire logic [15:0] hb_d_o,
   input  wire logic        hb_wait_o,
   output logic             cs_n_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic             a0_o,
   output logic [15:0]      d_o,
   output logic             boot_sel_o,
   output logic             done_o,
   output logic [31:0]      word_o
);
   int slow;
   initial begin
      {cs_n_o, rd_n_o, wr_n_o} = 3'b111;
      a0_o = 1'b0;
      d_o = 16'h0000;
      // strap high until the bench lowers it
      boot_sel_o = 1'b1;
      done_o = 1'b0;
      word_o = 32'h0000_0000;
      slow = 0;
   end
   // one strobe; a write first waits out a full queue
   task cyc(input logic a0, input logic wr, input logic [15:0] d,
            output logic [15:0] q);
      int i;
      for (i = 0; i < 200 && wr && hb_wait_o === 1'b1; i++)
         @(posedge clk_i);
      cs_n_o <= 1'b0;
      a0_o <= a0;
      d_o <= wr ? d : ~d_o;
      wr_n_o <= !wr;
      rd_n_o <= wr;
      repeat (LOW + slow) @(posedge clk_i);
      q = hb_d_o;
      {cs_n_o, rd_n_o, wr_n_o} <= 3'b111;
      d_o <= ~d_o;
      repeat (HIGH + slow) @(posedge clk_i);
   endtask : cyc
   task idx(input logic [7:0] v);
      logic [15:0] q;
      cyc(1'b1, 1'b1, {8'h00, v}, q);
   endtask : idx
   // upper half then lower half of one word
   task xfer(input logic wr, input logic [31:0] v);
      logic [15:0] h;
      logic [15:0] l;
      cyc(1'b0, wr, v[31:16], h);
      cyc(1'b0, wr, v[15:0], l);
      if (!wr) begin
         word_o <= {h, l};
         done_o <= 1'b1;
         @(posedge clk_i);
         done_o <= 1'b0;
      end
   endtask : xfer
   // key, clear and lock patterns come in through here
   task wreg(input logic [5:0] sel, input logic [31:0] v);
      idx({sel, 2'b00});
      xfer(1'b1, v);
   endtask : wreg
   task strap(input logic v);
      boot_sel_o <= v;
   endtask : strap
   task rreg(input logic [5:0] sel);
      idx({sel, 2'b00});
      xfer(1'b0, 32'h0000_0000);
   endtask : rreg
endmodule : hrw_host

/* dv/tb_top.sv */
// Purpose: self-checking bench of the host RAM window
// Assumes: host model drives the port, bench drives the cpu side
// Notes:   expected words queue up, monitors compare in order
`timescale 1ns/1ns
`include "hrw_consts.svh"

module tb_top;
   import hrw_pkg::*;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        cs_n, rd_n, wr_n, a0, bsel, hdone, en = 1'b0, en_q = 1'b0;
   logic        stall = 1'b0;
   logic [15:0] hd, hq;
   logic        oe_n, hwait, run;
   logic [7:0]  caddr = 8'h00;
   logic [31:0] crd, vec, hword;
   logic [31:0] w [0:22];
   logic [31:0] hexp [$];
   logic [31:0] cexp [$];
   int          fails = 0, comparisons = 0, cycles = 0, seed = 35, k;
   int          rd_lo = 0;

   hrw_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .hb_cs_n_i(cs_n),
      .hb_rd_n_i(rd_n), .hb_wr_n_i(wr_n), .hb_a0_i(a0), .hb_d_i(hd),
      .hb_d_o(hq), .hb_d_oe_n_o(oe_n), .hb_wait_o(hwait),
      .boot_select_input_i(bsel), .cpu_ram_en_i(en | stall),
      .cpu_ram_addr_i(caddr), .cpu_ram_rdata_o(crd), .cpu_run_o(run),
      .cpu_reset_vec_o(vec));
   hrw_host host (.clk_i(clk_i), .hb_d_o(hq), .hb_wait_o(hwait),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .a0_o(a0), .d_o(hd),
      .boot_sel_o(bsel), .done_o(hdone), .word_o(hword));

   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task cpu_rd(input logic [7:0] a, input logic [31:0] exp);
      en <= 1'b1;
      caddr <= a;
      cexp.push_back(exp);
      @(posedge clk_i);
      en <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : cpu_rd
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         test_done();
      end else begin
         // every host word read is checked
         if (hdone === 1'b1) begin
            chk(hword, hexp.pop_front());
            chk({31'h0, oe_n}, 32'h0000_0001);
         end
         if (en_q) chk(crd, cexp.pop_front());
         en_q <= en;
         // bus is driven three cycles after cs and rd fall
         if (!cs_n && !rd_n) rd_lo++;
         else rd_lo = 0;
         if (rd_lo == 4) chk({31'h0, oe_n}, 32'h0000_0000);
      end
   end

   initial begin
      for (k = 0; k < 23; k++) w[k] = $random(seed);
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({31'h0, run}, 32'h0);
      hexp.push_back(32'h0000_0001);
      host.rreg(`HRW_SEL_BCR);
      $display("test boot hold done");
      hexp.push_back(32'h0000_03FC);
      host.wreg(`HRW_SEL_ADR, 32'hFFFF_FFFF);
      host.rreg(`HRW_SEL_ADR);
      $display("test address done");
      host.wreg(`HRW_SEL_ADR, 32'h0000_0040);
      host.wreg(`HRW_SEL_DATA, w[0]);
      host.wreg(`HRW_SEL_MCR, 32'h0000_00A0);
      host.idx({`HRW_SEL_DATA, 2'b00});
      host.slow = 3;
      for (k = 1; k < 4; k++) host.xfer(1'b1, w[k]);
      host.slow = 0;
      host.wreg(`HRW_SEL_MCR, 32'h0000_0000);
      hexp.push_back(32'h0000_0050);
      host.rreg(`HRW_SEL_ADR);
      for (k = 0; k < 4; k++) cpu_rd(8'h10 + k[7:0], w[k]);
      $display("test burst up done");
      host.wreg(`HRW_SEL_ADR, 32'h0000_0080);
      host.wreg(`HRW_SEL_DATA, w[4]);
      host.wreg(`HRW_SEL_MCR, 32'h0000_00A1);
      host.idx({`HRW_SEL_DATA, 2'b00});
      host.xfer(1'b1, w[5]);
      host.wreg(`HRW_SEL_MCR, 32'h0000_0000);
      hexp.push_back(32'h0000_0078);
      host.rreg(`HRW_SEL_ADR);
      cpu_rd(8'h20, w[4]);
      cpu_rd(8'h1F, w[5]);
      $display("test burst down done");
      host.wreg(`HRW_SEL_ADR, 32'h0000_00C0);
      host.wreg(`HRW_SEL_DATA, w[6]);
      // drain stalled so that seventeen words overfill the queue
      stall <= 1'b1;
      host.wreg(`HRW_SEL_MCR, 32'h0000_00A0);
      host.idx({`HRW_SEL_DATA, 2'b00});
      fork
         for (k = 7; k < 23; k++) host.xfer(1'b1, w[k]);
         begin
            wait (hwait === 1'b1);
            @(posedge clk_i);
            chk({31'h0, hwait}, 32'h0000_0001);
            stall <= 1'b0;
         end
      join
      host.wreg(`HRW_SEL_MCR, 32'h0000_0000);
      cpu_rd(8'h30, w[6]);
      cpu_rd(8'h40, w[22]);
      $display("test queue full done");
      host.wreg(`HRW_SEL_ADR, 32'h0000_0044);
      host.wreg(`HRW_SEL_MCR, 32'h0000_0008);
      hexp.push_back(w[1]);
      host.rreg(`HRW_SEL_DATA);
      hexp.push_back(32'h0000_0000);
      host.rreg(`HRW_SEL_MCR);
      host.wreg(`HRW_SEL_ADR, 32'h0000_0040);
      host.wreg(`HRW_SEL_MCR, 32'h0000_0088);
      host.idx({`HRW_SEL_DATA, 2'b00});
      for (k = 0; k < 4; k++) begin
         hexp.push_back(w[k]);
         host.xfer(1'b0, 32'h0000_0000);
      end
      host.wreg(`HRW_SEL_MCR, 32'h0000_0000);
      $display("test read done");
      host.wreg(`HRW_SEL_ADR, 32'h0000_0000);
      host.wreg(`HRW_SEL_DATA, w[5]);
      host.wreg(`HRW_SEL_MCR, 32'h0000_0020);
      host.wreg(`HRW_SEL_BCR, 32'h0000_00A5);
      repeat (4) @(posedge clk_i);
      chk({31'h0, run}, 32'h0);
      host.wreg(`HRW_SEL_BCR, 32'h0000_0000);
      repeat (4) @(posedge clk_i);
      chk({31'h0, run}, 32'h1);
      chk(vec, w[5]);
      $display("test release done");
      // second reset with the strap low: no host boot
      host.strap(1'b0);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({31'h0, run}, 32'h1);
      chk(vec, w[5]);
      hexp.push_back(32'h0000_0000);
      host.rreg(`HRW_SEL_BCR);
      host.wreg(`HRW_SEL_BCR, 32'h0000_00A5);
      hexp.push_back(32'h0000_0001);
      host.rreg(`HRW_SEL_BCR);
      $display("test strap low done");
      repeat (4) @(posedge clk_i);
      test_done();
   end
endmodule : tb_top

/* hdl/hrw_top.sv */
// Overview of operation
// - address register: word address bits 9..2
// - data register is full 32 bits
// - hold flag set on host boot startup
// - index bits 7..2 select internal register
// - index bit 1 selects half word
// - burst write needs lock and write bits
// - write bit stores data word to RAM
// - read bit fetches RAM word into data
// - lock, direction 0: address plus four
// - read bit self-clears after fetch when lock is clear
// - boot select sampled at reset release
// - released processor takes word zero vector
// Purpose: host port with indirect window onto a shared RAM
// Assumes: host honours hb_wait_o before each write strobe
// Notes:   write requests queue in a FIFO ahead of the RAM
`timescale 1ns/1ns
`include "hrw_consts.svh"

module hrw_fifo #(
   parameter int W = 40,
   parameter int D = 16
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
   logic         push, pop;
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop  = out_valid_o && out_ready_i;
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wp_q[AW-1:0]] <= in_data_i;
      end
   end
   assign in_ready_o  = !((wp_q[AW] != rp_q[AW]) &&
                          (wp_q[AW-1:0] == rp_q[AW-1:0]));
   assign out_valid_o = (wp_q != rp_q);
   assign out_data_o  = mem_q[rp_q[AW-1:0]];
endmodule : hrw_fifo

module hrw_top #(
   parameter int FIFO_DEPTH = `HRW_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // host parallel port
   input  wire logic        hb_cs_n_i,
   input  wire logic        hb_rd_n_i,
   input  wire logic        hb_wr_n_i,
   input  wire logic        hb_a0_i,
   input  wire logic [15:0] hb_d_i,
   output logic      [15:0] hb_d_o,
   output logic             hb_d_oe_n_o,
   output logic             hb_wait_o,
   // boot strap
   input  wire logic        boot_select_input_i,
   // embedded processor side
   input  wire logic        cpu_ram_en_i,
   input  wire logic [7:0]  cpu_ram_addr_i,
   output logic      [31:0] cpu_ram_rdata_o,
   output logic             cpu_run_o,
   output logic      [31:0] cpu_reset_vec_o
);
   import hrw_pkg::*;
   logic [31:0]  ram_q [`HRW_RAM_WORDS];
   // synchronisers: stage one read only by stage two
   logic [19:0]  s1_q, s2_q;
   logic         wr_prev_q, rd_prev_q;
   logic         bsel1_q, bsel2_q;
   logic         cs_s, rd_s, wr_s, a0_s;
   logic [15:0]  d_s;
   logic [7:0]   adr_q, adr_d;
   logic [31:0]  data_q, data_d;
   logic [7:0]   idx_q, idx_d;
   logic         lock_q, lock_d, wt_q, wt_d, rd_q, rd_d, dir_q, dir_d;
   logic         hold_q, hold_d, fetch_q, fetch_d;
   hrw_su_t      su_q, su_d;
   logic [15:0]  hbd_q, hbd_d;
   logic         oe_n_q, oe_n_d, run_q, run_d;
   logic [31:0]  vec_q, vec_d, crd_q;
   logic         wr_ev, rd_ev, push, f_rdy, f_vld, drain;
   hrw_wreq_t    push_w, pop_w;
   logic [31:0]  sel_val;
   logic [7:0]   step_adr;

   always_comb begin
      {cs_s, rd_s, wr_s, a0_s, d_s} = s2_q;
      wr_ev = !cs_s && !wr_s && wr_prev_q;
      rd_ev = !cs_s && !rd_s && rd_prev_q;
   end

   assign step_adr = dir_q ? adr_q - `HRW_ADDR_STEP
                           : adr_q + `HRW_ADDR_STEP;

   always_comb begin
      case (idx_q[7:2])
         `HRW_SEL_ADR:  sel_val = {22'h0, adr_q, 2'h0};
         `HRW_SEL_DATA: sel_val = data_q;
         `HRW_SEL_BCR:  sel_val = {31'h0, hold_q};
         `HRW_SEL_MCR:  sel_val = {24'h0, lock_q, 1'b0, wt_q, 1'b0,
                                  rd_q, 2'h0, dir_q};
         default:       sel_val = 32'h0;
      endcase
   end

   always_comb begin
      adr_d   = adr_q;
      data_d  = data_q;
      idx_d   = idx_q;
      lock_d  = lock_q;
      wt_d    = wt_q;
      rd_d    = rd_q;
      dir_d   = dir_q;
      hold_d  = hold_q;
      fetch_d = fetch_q;
      su_d    = su_q;
      hbd_d   = hbd_q;
      oe_n_d  = !(!cs_s && !rd_s);
      run_d   = run_q;
      vec_d   = vec_q;
      push    = 1'b0;
      push_w  = '{addr: adr_q, data: data_q};
      // strap read once both sync stages hold it
      case (su_q)
         HRW_SU_SYNC0: su_d = HRW_SU_SYNC1;
         HRW_SU_SYNC1: su_d = HRW_SU_SYNC2;
         HRW_SU_SYNC2: begin
            su_d = HRW_SU_DONE;
            hold_d = bsel2_q;
         end
         HRW_SU_DONE: ;
         default: su_d = HRW_SU_SYNC0;
      endcase
      if (su_q == HRW_SU_DONE && !hold_q && !run_q) begin
         run_d = 1'b1;
         vec_d = ram_q[0];
      end
      if (fetch_q && !f_vld) begin
         data_d  = ram_q[adr_q];
         fetch_d = 1'b0;
         rd_d    = lock_q;
      end
      if (rd_ev) begin
         hbd_d = a0_s ? {8'h0, idx_q} :
                 (idx_q[1] ? sel_val[15:0] : sel_val[31:16]);
         if (!a0_s) begin
            idx_d[1] = !idx_q[1];
         end
         if (!a0_s && idx_q[7:2] == `HRW_SEL_DATA && idx_q[1] &&
             lock_q && rd_q) begin
            adr_d   = step_adr;
            fetch_d = 1'b1;
         end
      end
      if (wr_ev && a0_s) begin
         idx_d = d_s[7:0];
      end else if (wr_ev) begin
         idx_d[1] = !idx_q[1];
         case (idx_q[7:2])
            `HRW_SEL_ADR: begin
               if (idx_q[1]) begin
                  adr_d = d_s[9:2];
               end
            end
            `HRW_SEL_DATA: begin
               if (idx_q[1]) begin
                  data_d[15:0] = d_s;
                  if (lock_q && wt_q) begin
                     push   = 1'b1;
                     push_w = '{addr: adr_q, data: {data_q[31:16], d_s}};
                     adr_d  = step_adr;
                  end
               end else begin
                  data_d[31:16] = d_s;
               end
            end
            `HRW_SEL_BCR: begin
               if (idx_q[1]) begin
                  if (d_s[7:0] == `HRW_BOOT_KEY) begin
                     hold_d = 1'b1;
                  end else if (!d_s[`HRW_HOLD_BIT]) begin
                     hold_d = 1'b0;
                  end
               end
            end
            `HRW_SEL_MCR: begin
               if (idx_q[1]) begin
                  lock_d = d_s[`HRW_MCR_LOCK];
                  dir_d  = d_s[`HRW_MCR_DIR];
                  wt_d   = d_s[`HRW_MCR_WT] && d_s[`HRW_MCR_LOCK];
                  rd_d   = d_s[`HRW_MCR_RD];
                  if (d_s[`HRW_MCR_WT]) begin
                     push = 1'b1;
                     if (d_s[`HRW_MCR_LOCK]) begin
                        adr_d = dir_d ? adr_q - `HRW_ADDR_STEP
                                      : adr_q + `HRW_ADDR_STEP;
                     end
                  end
                  fetch_d = d_s[`HRW_MCR_RD];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q      <= 20'hF0000;
         s2_q      <= 20'hF0000;
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
         bsel1_q   <= 1'b0;
         bsel2_q   <= 1'b0;
         adr_q     <= 8'h00;
         data_q    <= 32'h0;
         idx_q     <= 8'h00;
         lock_q    <= 1'b0;
         wt_q      <= 1'b0;
         rd_q      <= 1'b0;
         dir_q     <= 1'b0;
         hold_q    <= 1'b1;
         fetch_q   <= 1'b0;
         su_q      <= HRW_SU_SYNC0;
         hbd_q     <= 16'h0;
         oe_n_q    <= 1'b1;
         run_q     <= 1'b0;
         vec_q     <= 32'h0;
      end else begin
         s1_q      <= {hb_cs_n_i, hb_rd_n_i, hb_wr_n_i, hb_a0_i, hb_d_i};
         s2_q      <= s1_q;
         wr_prev_q <= s2_q[17] | s2_q[19];
         rd_prev_q <= s2_q[18] | s2_q[19];
         bsel1_q   <= boot_select_input_i;
         bsel2_q   <= bsel1_q;
         adr_q     <= adr_d;
         data_q    <= data_d;
         idx_q     <= idx_d;
         lock_q    <= lock_d;
         wt_q      <= wt_d;
         rd_q      <= rd_d;
         dir_q     <= dir_d;
         hold_q    <= hold_d;
         fetch_q   <= fetch_d;
         su_q      <= su_d;
         hbd_q     <= hbd_d;
         oe_n_q    <= oe_n_d;
         run_q     <= run_d;
         vec_q     <= vec_d;
      end
   end

   // processor port wins the RAM, stalling the drain
   assign drain = f_vld && !cpu_ram_en_i;
   always_ff @(posedge clk_i) begin
      if (drain) begin
         ram_q[pop_w.addr] <= pop_w.data;
      end
      crd_q <= ram_q[cpu_ram_addr_i];
   end

   hrw_fifo #(.W($bits(hrw_wreq_t)), .D(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (push),
      .in_ready_o  (f_rdy),
      .in_data_i   (push_w),
      .out_valid_o (f_vld),
      .out_ready_i (!cpu_ram_en_i),
      .out_data_o  (pop_w)
   );

   logic wait_q;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= !f_rdy;
      end
   end

   assign hb_d_o          = hbd_q;
   assign hb_d_oe_n_o     = oe_n_q;
   assign hb_wait_o       = wait_q;
   assign cpu_ram_rdata_o = crd_q;
   assign cpu_run_o       = run_q;
   assign cpu_reset_vec_o = vec_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence burst_wr_s;
      wr_ev && !a0_s && idx_q[7:2] == `HRW_SEL_DATA && idx_q[1] &&
      lock_q && wt_q;
   endsequence
   burst_step_a: assert property (burst_wr_s |=>
      adr_q == $past(step_adr)) else $error("burst address not stepped");
   burst_push_a: assert property (burst_wr_s |-> push)
      else $error("burst write not queued");
   rd_clear_a: assert property (
      fetch_q && !f_vld && !lock_q |=> !rd_q && !fetch_q)
      else $error("read bit not cleared after fetch");
   fetch_data_a: assert property (
      fetch_q && !f_vld |=> data_q == ram_q[$past(adr_q)])
      else $error("fetched word not loaded");
   boot_hold_a: assert property (
      su_q == HRW_SU_SYNC2 |=> hold_q == $past(bsel2_q))
      else $error("hold flag does not follow boot strap");
   key_set_a: assert property (
      wr_ev && !a0_s && idx_q == {`HRW_SEL_BCR, 2'b10} &&
      d_s[7:0] == `HRW_BOOT_KEY |=> hold_q)
      else $error("key pattern did not set hold");
   release_run_a: assert property (
      su_q == HRW_SU_DONE && !hold_q |=> ##[0:1] run_q)
      else $error("processor not released");
   vec_word_a: assert property (
      $rose(run_q) |-> vec_q == ram_q[0])
      else $error("reset vector not word zero");
   adr_zero_a: assert property (
      rd_ev && !a0_s && idx_q[7:2] == `HRW_SEL_ADR |=>
      hbd_q[1:0] == 2'h0 && hbd_q[15:10] == 6'h0)
      else $error("address reserved bits set");
   wt_push_a: assert property (
      wr_ev && !a0_s && idx_q == {`HRW_SEL_MCR, 2'b10} &&
      d_s[`HRW_MCR_WT] |-> push) else $error("write bit not queued");
   wait_full_a: assert property (!f_rdy |=> hb_wait_o)
      else $error("wait not raised on full queue");
   half_sel_a: assert property (
      rd_ev && !a0_s && !idx_q[1] |=> hbd_q == $past(sel_val[31:16]))
      else $error("upper half not returned");
endmodule : hrw_top

/* include/hrw_consts.svh */
// Purpose: constants of the host RAM window access block
// Assumes: included by the package and the design file
// Notes:   definitions only
`ifndef HRW_CONSTS_SVH
`define HRW_CONSTS_SVH
// selector codes of the internal registers, index bits 7..2
`define HRW_SEL_ADR     6'h00
`define HRW_SEL_DATA    6'h01
`define HRW_SEL_BCR     6'h02
`define HRW_SEL_MCR     6'h03
// window access control bit positions
`define HRW_MCR_LOCK    7
`define HRW_MCR_WT      5
`define HRW_MCR_RD      3
`define HRW_MCR_DIR     0
// boot hold control
`define HRW_BOOT_KEY    8'hA5
`define HRW_HOLD_BIT    0
// word address step, one word is four bytes
`define HRW_ADDR_STEP   8'h01
`define HRW_RAM_WORDS   256
`define HRW_FIFO_DEPTH  16
`endif

/* include/hrw_pkg.sv */
// Purpose: types of the host RAM window access block
// Assumes: hrw_consts.svh on the include path
// Notes:   none
`include "hrw_consts.svh"
package hrw_pkg;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
   } hrw_wreq_t;
   typedef enum logic [1:0] {
      HRW_SU_SYNC0 = 2'b00,
      HRW_SU_SYNC1 = 2'b01,
      HRW_SU_DONE  = 2'b10,
      HRW_SU_SYNC2 = 2'b11
   } hrw_su_t;
endpackage : hrw_pkg
